// ---- shared/tlb_pkg.sv ----
// constants, register map and state codes for the page translator
// assumes one 200 MHz clock and a 32-bit avalon-mm register port
package xlat_pkg;
  localparam int ADDR_W = 24;
  localparam int PAGE_LSB = 12;
  localparam int SEG_LSB = 19;
  localparam int N_MAPS = 16;
  localparam int N_SEGS = 32;
  localparam int PAGES_PER_SEG = 128;
  localparam int N_PAGES = 4096;
  localparam int N_RECS = N_MAPS * N_SEGS;
  localparam int SYNC_W = 20;

  // register byte offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_USER_MAP = 8'h04;
  localparam logic [7:0] REG_SUPER_MAP = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_SEG_INDEX = 8'h10;
  localparam logic [7:0] REG_SEG_MODE = 8'h14;
  localparam logic [7:0] REG_SEG_PTR = 8'h18;
  localparam logic [7:0] REG_ERR_PAGE = 8'h1C;
  localparam logic [7:0] REG_SEG_ACTIVE = 8'h20;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_SEGERR_BIT = 0;
  localparam int STAT_TLBERR_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_SELPTR_BIT = 3;
  localparam int MODE_INUSE_BIT = 6;
  localparam int MODE_RESIDENT_BIT = 5;
  localparam int MODE_TYPE_LSB = 0;
  localparam int PTE_PPN_LSB = 0;
  localparam int PTE_TYPE_LSB = 12;
  localparam int PTE_RESIDENT_BIT = 15;
  localparam int ERRP_SUPER_BIT = 12;

  // reset values
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic [3:0] MAP_RESET = 4'h0;
  localparam logic [8:0] INDEX_RESET = 9'h000;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_CHECK = 7'h02,
    S_FLUSH = 7'h04,
    S_GRANT = 7'h08,
    S_READ  = 7'h10,
    S_DROP  = 7'h20,
    S_HOLD  = 7'h40
  } walk_state_e;
endpackage

// ---- src/pin_sync.sv ----
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to sys_clk; output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      meta <= pin;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // per-bit filter keeps a single-cycle glitch at stage two from passing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// ---- src/segmented_page_tlb_translator.sv ----
// segmented page translator: segment tables, lookaside buffer and miss walker
// assumes processor request logic on sys_clk; s-100 bus pins asynchronous
// What this block does
// - address space is 4096 pages of 4K; upper twelve bits pick the page
// - only the page number is replaced; byte offset passes unchanged
// - 32 segments of 128 pages; A23-A19 segment, A18-A12 local page
// - sixteen segment tables of 32 records; any one can be picked by either map register
// - record holds in-use, resident, 5-bit type, 16-bit pointer; active flag beside
// - unmapped segment raises segment error and is not translated
// - a select line picks mode part or pointer part of a record
// - page record is 12-bit page, 3-bit type, resident flag; 128 per table
// - 4096-record lookaside buffer indexed by A23-A12, shared by all
// - each buffer record has a valid flag set when filled from memory
// - user and supervisor map registers; current mode picks the table
// - active segment and valid record: page taken from buffer, no bus
// - inactive segment: flush its 128 valid flags, move active flag here
// - writing a new page table pointer clears the segment active flag unless a flush sets that flag in the same cycle
// - miss takes the bus first, drives pointer on A23-A8
// - local page on A7-A1, A0 held low for a word fetch
// - one word read fills the record, sets valid, bus handed back
// - failed or narrow fetch records buffer error and signals bus error
// - active segment with clear valid skips flush, goes to bus fetch
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module segmented_page_tlb_translator
  import xlat_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_req,
  input wire logic [23:0] cpu_addr,
  input wire logic cpu_super,
  output logic cpu_ack,
  output logic [23:0] cpu_phys_addr,
  output logic cpu_seg_fault,
  output logic cpu_bus_error,
  output logic bus_req,
  input wire logic bus_grant,
  output logic [23:0] bus_addr,
  output logic bus_rd,
  output logic bus_word,
  input wire logic bus_done,
  input wire logic bus_error,
  input wire logic bus_wide16,
  input wire logic [15:0] bus_rdata,
  output logic seg_field_select
);
  walk_state_e state;
  logic enable;
  logic [3:0] user_map;
  logic [3:0] super_map;
  logic seg_err;
  logic buf_err;
  logic [8:0] seg_index;
  logic [12:0] err_page;
  logic walk_fail;

  // storage: tables and buffer have no reset, software initialises the tables before enabling, the walker fills the buffer; active and valid flags reset to zero
  logic [6:0] seg_mode [0:N_RECS-1];
  logic [15:0] seg_ptr [0:N_RECS-1];
  logic [N_RECS-1:0] seg_act;
  logic [15:0] lookaside_buffer [0:N_PAGES-1];
  logic [N_PAGES-1:0] valid;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic grant_s;
  logic done_s;
  logic err_s;
  logic wide_s;
  logic [15:0] rdata_s;

  assign sync_in = {bus_grant, bus_done, bus_error, bus_wide16, bus_rdata};

  pin_sync #(.W(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(sync_in),
    .level(sync_out)
  );

  assign grant_s = sync_out[19];
  assign done_s = sync_out[18];
  assign err_s = sync_out[17];
  assign wide_s = sync_out[16];
  assign rdata_s = sync_out[15:0];

  // address split
  logic [4:0] seg_no;
  logic [6:0] local_page;
  logic [11:0] vpn;
  logic [3:0] cur_map;
  logic [8:0] cur_idx;
  assign vpn = cpu_addr[ADDR_W-1:PAGE_LSB];
  assign seg_no = cpu_addr[ADDR_W-1:SEG_LSB];
  assign local_page = cpu_addr[SEG_LSB-1:PAGE_LSB];
  assign cur_map = cpu_super ? super_map : user_map;
  assign cur_idx = {cur_map, seg_no};

  // one record port, its field chosen by the select line
  logic [15:0] rec_word;
  logic [15:0] pte;
  logic rec_in_use;
  logic fetch_ok;
  assign rec_word = seg_field_select ? seg_ptr[cur_idx] : {9'h000, seg_mode[cur_idx]};
  assign rec_in_use = rec_word[MODE_INUSE_BIT];
  assign pte = lookaside_buffer[vpn];
  assign fetch_ok = !err_s && wide_s;

  // register port
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wdat;
  assign wr_go = avs_write && !avs_waitrequest;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdat = avs_writedata & wmask;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (avs_address == REG_CONTROL) begin
      next_readdata[CTRL_ENABLE_BIT] = enable;
    end else if (avs_address == REG_USER_MAP) begin
      next_readdata[3:0] = user_map;
    end else if (avs_address == REG_SUPER_MAP) begin
      next_readdata[3:0] = super_map;
    end else if (avs_address == REG_STATUS) begin
      next_readdata[STAT_SEGERR_BIT] = seg_err;
      next_readdata[STAT_TLBERR_BIT] = buf_err;
      next_readdata[STAT_BUSY_BIT] = (state != S_IDLE);
      next_readdata[STAT_SELPTR_BIT] = seg_field_select;
    end else if (avs_address == REG_SEG_INDEX) begin
      next_readdata[8:0] = seg_index;
    end else if (avs_address == REG_SEG_MODE) begin
      next_readdata[6:0] = seg_mode[seg_index];
    end else if (avs_address == REG_SEG_PTR) begin
      next_readdata[15:0] = seg_ptr[seg_index];
    end else if (avs_address == REG_ERR_PAGE) begin
      next_readdata[12:0] = err_page;
    end else if (avs_address == REG_SEG_ACTIVE) begin
      next_readdata[0] = seg_act[seg_index];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enable <= ENABLE_RESET;
      user_map <= MAP_RESET;
      super_map <= MAP_RESET;
      seg_index <= INDEX_RESET;
    end else if (wr_go) begin
      if (avs_address == REG_CONTROL && avs_byteenable[0]) begin
        enable <= avs_writedata[CTRL_ENABLE_BIT];
      end else if (avs_address == REG_USER_MAP && avs_byteenable[0]) begin
        user_map <= avs_writedata[3:0];
      end else if (avs_address == REG_SUPER_MAP && avs_byteenable[0]) begin
        super_map <= avs_writedata[3:0];
      end else if (avs_address == REG_SEG_INDEX) begin
        seg_index <= (seg_index & ~wmask[8:0]) | wdat[8:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_go && avs_address == REG_SEG_MODE && avs_byteenable[0]) begin
      seg_mode[seg_index] <= avs_writedata[6:0];
    end
    if (wr_go && avs_address == REG_SEG_PTR) begin
      seg_ptr[seg_index] <= (seg_ptr[seg_index] & ~wmask[15:0]) | wdat[15:0];
    end
  end

  // sticky errors: hardware set beats a same-cycle write-one clear
  logic seg_err_set;
  logic buf_err_set;
  logic [1:0] err_clr;
  assign seg_err_set = (state == S_CHECK) && enable && !rec_in_use;
  assign buf_err_set = (state == S_READ) && done_s && !fetch_ok;
  assign err_clr = (wr_go && avs_address == REG_STATUS && avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seg_err <= 1'b0;
      buf_err <= 1'b0;
      err_page <= 13'h0000;
    end else begin
      seg_err <= seg_err_set || (seg_err && !err_clr[STAT_SEGERR_BIT]);
      buf_err <= buf_err_set || (buf_err && !err_clr[STAT_TLBERR_BIT]);
      if (seg_err_set || buf_err_set) begin
        err_page <= {cpu_super, vpn};
      end
    end
  end

  // segment active flags, written by the walker and by pointer writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seg_act <= '0;
    end else begin
      if (wr_go && avs_address == REG_SEG_PTR) begin
        seg_act[seg_index] <= 1'b0;
      end
      if (state == S_FLUSH) begin
        for (int m = 0; m < N_MAPS; m++) begin
          seg_act[{m[3:0], seg_no}] <= 1'b0;
        end
        seg_act[cur_idx] <= 1'b1;
      end
    end
  end

  // valid flags and buffer fill
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valid <= '0;
    end else if (state == S_FLUSH) begin
      valid[{seg_no, 7'h00} +: PAGES_PER_SEG] <= '0;
    end else if (state == S_READ && done_s && fetch_ok) begin
      valid[vpn] <= 1'b1;
    end
  end

  // the page record goes in whole: page, type and resident flag
  always_ff @(posedge sys_clk) begin
    if (state == S_READ && done_s && fetch_ok) begin
      lookaside_buffer[vpn] <= rdata_s;
    end
  end

  // translation walker
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= S_IDLE;
      cpu_ack <= 1'b0;
      cpu_phys_addr <= 24'h00_0000;
      cpu_seg_fault <= 1'b0;
      cpu_bus_error <= 1'b0;
      bus_req <= 1'b0;
      bus_rd <= 1'b0;
      bus_word <= 1'b0;
      bus_addr <= 24'h00_0000;
      seg_field_select <= 1'b0;
      walk_fail <= 1'b0;
    end else begin
      cpu_ack <= 1'b0;
      cpu_seg_fault <= 1'b0;
      cpu_bus_error <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cpu_req) begin
            state <= S_CHECK;
          end
        end
        S_CHECK: begin
          walk_fail <= 1'b0;
          if (!enable) begin
            cpu_ack <= 1'b1;
            cpu_phys_addr <= cpu_addr;
            state <= S_HOLD;
          end else if (!rec_in_use) begin
            cpu_ack <= 1'b1;
            cpu_seg_fault <= 1'b1;
            state <= S_HOLD;
          end else if (seg_act[cur_idx] && valid[vpn]) begin
            cpu_ack <= 1'b1;
            cpu_phys_addr <= {pte[PTE_TYPE_LSB-1:PTE_PPN_LSB], cpu_addr[PAGE_LSB-1:0]};
            state <= S_HOLD;
          end else if (!seg_act[cur_idx]) begin
            state <= S_FLUSH;
          end else begin
            bus_req <= 1'b1;
            seg_field_select <= 1'b1;
            state <= S_GRANT;
          end
        end
        S_FLUSH: begin
          bus_req <= 1'b1;
          seg_field_select <= 1'b1;
          state <= S_GRANT;
        end
        S_GRANT: begin
          if (grant_s) begin
            bus_addr <= {rec_word, local_page, 1'b0};
            bus_rd <= 1'b1;
            bus_word <= 1'b1;
            state <= S_READ;
          end
        end
        S_READ: begin
          if (done_s) begin
            bus_rd <= 1'b0;
            bus_word <= 1'b0;
            bus_req <= 1'b0;
            seg_field_select <= 1'b0;
            walk_fail <= !fetch_ok;
            state <= S_DROP;
          end
        end
        S_DROP: begin
          // wait for the bus to settle so a stale done cannot end the next fetch
          if (!done_s && !grant_s) begin
            if (walk_fail) begin
              cpu_ack <= 1'b1;
              cpu_bus_error <= 1'b1;
              state <= S_HOLD;
            end else begin
              state <= S_CHECK;
            end
          end
        end
        S_HOLD: begin
          if (!cpu_req) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // checks
  sequence s_fill_done;
    state == S_READ && done_s && fetch_ok;
  endsequence

  sequence s_fill_fail;
    state == S_READ && done_s && !fetch_ok;
  endsequence

  property p_offset_kept;
    @(posedge sys_clk) disable iff (rst)
      cpu_ack && !cpu_seg_fault && !cpu_bus_error |-> cpu_phys_addr[11:0] == $past(cpu_addr[11:0]);
  endproperty

  property p_fill_sets_valid;
    @(posedge sys_clk) disable iff (rst)
      s_fill_done |=> valid[$past(vpn)] && lookaside_buffer[$past(vpn)] == $past(rdata_s) && !bus_rd;
  endproperty

  a_offset_kept: assert property (p_offset_kept) else $error("byte offset changed");
  a_word_align: assert property (@(posedge sys_clk) disable iff (rst)
    bus_rd |-> bus_addr[0] == 1'b0 && bus_addr[7:1] == local_page) else $error("fetch address low bits wrong");
  a_ptr_on_bus: assert property (@(posedge sys_clk) disable iff (rst)
    bus_rd |-> bus_addr[23:8] == seg_ptr[cur_idx]) else $error("pointer not on upper address");
  a_grant_first: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(bus_rd) |-> bus_req && $past(grant_s)) else $error("read before bus taken");
  a_flush_segment: assert property (@(posedge sys_clk) disable iff (rst)
    state == S_FLUSH |=> valid[{$past(seg_no), 7'h00} +: PAGES_PER_SEG] == '0 && seg_act[$past(cur_idx)])
    else $error("flush incomplete");
  a_fill_valid: assert property (p_fill_sets_valid) else $error("fill did not set valid");
  a_fill_error: assert property (@(posedge sys_clk) disable iff (rst)
    s_fill_fail |=> buf_err ##[1:20] cpu_ack && cpu_bus_error) else $error("failed fetch not reported");
  a_unmapped_fault: assert property (@(posedge sys_clk) disable iff (rst)
    state == S_CHECK && enable && !rec_in_use |=> cpu_ack && cpu_seg_fault && seg_err) else $error("unmapped not faulted");
  a_hit_no_bus: assert property (@(posedge sys_clk) disable iff (rst)
    state == S_CHECK && enable && rec_in_use && seg_act[cur_idx] && valid[vpn] |=> cpu_ack && !bus_req)
    else $error("hit used the bus");
  a_ptr_clears_act: assert property (@(posedge sys_clk) disable iff (rst)
    wr_go && avs_address == REG_SEG_PTR && state != S_FLUSH |=> !seg_act[$past(seg_index)])
    else $error("pointer write kept active");
  a_disabled_pass: assert property (@(posedge sys_clk) disable iff (rst)
    state == S_CHECK && !enable |=> cpu_ack && cpu_phys_addr == $past(cpu_addr)) else $error("disabled not passthrough");
  a_skip_flush: assert property (@(posedge sys_clk) disable iff (rst)
    state == S_CHECK && enable && rec_in_use && seg_act[cur_idx] && !valid[vpn] |=> state == S_GRANT && bus_req)
    else $error("active miss flushed");
endmodule

// ---- bench/s100_mem_model.sv ----
// behavioural s-100 bus master arbiter and word memory for the translator's fetches
// assumes the translator drives bus_req, bus_rd and bus_addr from sys_clk
`timescale 1ns/1ps
module s100_mem_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic bus_req,
  output logic bus_grant,
  input wire logic [23:0] bus_addr,
  input wire logic bus_rd,
  output logic bus_done,
  output logic bus_error,
  output logic bus_wide16,
  output logic [15:0] bus_rdata,
  input wire logic [2:0] lat,
  input wire logic fail,
  input wire logic narrow
);
  logic [3:0] cnt;
  always @(posedge sys_clk) begin
    if (rst) begin
      bus_grant <= 1'b0;
      bus_done <= 1'b0;
      bus_error <= 1'b0;
      bus_wide16 <= 1'b0;
      bus_rdata <= 16'h0000;
      cnt <= 4'h0;
    end else begin
      // grant only while asked; lat gives prompt and slow arbitration
      if (!bus_req) begin
        bus_grant <= 1'b0;
      end else if (!bus_grant) begin
        cnt <= (cnt >= {1'b0, lat}) ? 4'h0 : cnt + 4'h1;
        bus_grant <= (cnt >= {1'b0, lat});
      end else if (bus_rd && !bus_done) begin
        cnt <= (cnt >= {1'b0, lat}) ? 4'h0 : cnt + 4'h1;
        if (cnt >= {1'b0, lat}) begin
          bus_done <= 1'b1;
          bus_rdata <= bus_addr[16:1] ^ 16'h8C35;
          bus_error <= fail;
          bus_wide16 <= !narrow;
        end
      end
      // released lines do not keep the last value
      if (!bus_rd && bus_done) begin
        bus_done <= 1'b0;
        bus_rdata <= ~bus_rdata;
        bus_error <= ~bus_error;
        bus_wide16 <= ~bus_wide16;
      end
    end
  end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the segmented page translator
// assumes the memory model on the bus side and a 200 MHz sys_clk
`timescale 1ns/1ps
module tb
  import xlat_pkg::*;
;
  typedef struct {logic [23:0] ph; logic f; logic b;} ans_s;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, cpu_req, cpu_super, cpu_ack;
  logic cpu_seg_fault, cpu_bus_error, bus_req, bus_grant, bus_rd, bus_word, bus_done;
  logic bus_error, bus_wide16, seg_field_select, fail, narrow;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [23:0] cpu_addr, cpu_phys_addr, bus_addr, a;
  logic [15:0] bus_rdata;
  logic [2:0] lat;
  logic rd_q;
  int mismatches, total_checks, nfetch, seed, i;
  ans_s cq[$];
  logic [23:0] bq[$];
  logic [31:0] rq[$];

  segmented_page_tlb_translator dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_super(cpu_super), .cpu_ack(cpu_ack),
    .cpu_phys_addr(cpu_phys_addr), .cpu_seg_fault(cpu_seg_fault), .cpu_bus_error(cpu_bus_error),
    .bus_req(bus_req), .bus_grant(bus_grant), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_word(bus_word), .bus_done(bus_done), .bus_error(bus_error), .bus_wide16(bus_wide16),
    .bus_rdata(bus_rdata), .seg_field_select(seg_field_select));
  s100_mem_model mem (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_grant(bus_grant),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_done(bus_done), .bus_error(bus_error),
    .bus_wide16(bus_wide16), .bus_rdata(bus_rdata), .lat(lat), .fail(fail), .narrow(narrow));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // page record as the memory model returns it: low 12 bits become the page
  function automatic logic [23:0] pa(input logic [15:0] p, input logic [23:0] la);
    return {({p[4:0], la[18:12]} ^ 12'hC35), la[11:0]};
  endfunction

  task automatic reg_io(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // no local limit: only the watchdog ends a wait
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    rq.push_back(exp);
    reg_io(1'b0, ad, 32'h0);
  endtask

  task automatic seg_set(input logic [3:0] m, input logic [4:0] s, input logic use_it, input logic [15:0] p);
    reg_io(1'b1, REG_SEG_INDEX, {23'h0, m, s});
    reg_io(1'b1, REG_SEG_MODE, {25'h0, use_it, 1'b1, 5'h0A});
    reg_io(1'b1, REG_SEG_PTR, {16'h0, p});
  endtask

  task automatic xlate(input logic [23:0] la, input logic sup, input logic [23:0] ph, input logic f,
                       input logic b, input logic fe, input logic [15:0] p);
    int n0;
    ans_s e;
    e.ph = ph;
    e.f = f;
    e.b = b;
    cq.push_back(e);
    if (fe) bq.push_back({p, la[18:12], 1'b0});
    n0 = nfetch;
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_addr <= la;
    cpu_super <= sup;
    lat <= 3'($random(seed));
    do begin
      @(posedge sys_clk);
    end while (cpu_ack !== 1'b1);
    cpu_req <= 1'b0;
    @(posedge sys_clk);
    chk("fetch count", 32'(nfetch - n0), {31'h0, fe});
  endtask

  always @(posedge sys_clk) begin
    if (cpu_ack === 1'b1) begin
      ans_s e;
      e = cq.pop_front();
      chk("seg fault", {31'h0, cpu_seg_fault}, {31'h0, e.f});
      chk("bus error", {31'h0, cpu_bus_error}, {31'h0, e.b});
      chk("field select", {31'h0, seg_field_select}, 32'h0);
      if (!e.f && !e.b) chk("phys addr", {8'h0, cpu_phys_addr}, {8'h0, e.ph});
    end
    if (bus_rd === 1'b1 && rd_q !== 1'b1) begin
      nfetch++;
      chk("bus addr", {8'h0, bus_addr}, {8'h0, bq.pop_front()});
      chk("word read", {31'h0, bus_word}, 32'h1);
      chk("field select", {31'h0, seg_field_select}, 32'h1);
      chk("bus request", {31'h0, bus_req}, 32'h1);
    end
    rd_q = bus_rd;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk("reg read", avs_readdata, rq.pop_front());
  end

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (50000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    seed = 32'h05502061;
    {rst, avs_read, avs_write, cpu_req, cpu_super, fail, narrow, rd_q} = 8'h80;
    {avs_address, avs_writedata, cpu_addr, lat} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(REG_CONTROL, 32'h0);
    rd(REG_USER_MAP, 32'h0);
    a = 24'($random(seed));
    xlate(a, 1'b0, a, 1'b0, 1'b0, 1'b0, 16'h0);
    seg_set(4'h3, 5'd2, 1'b1, 16'h0123);
    rd(REG_SEG_MODE, 32'h0000006A);
    seg_set(4'h7, 5'd2, 1'b1, 16'h0456);
    seg_set(4'h3, 5'd4, 1'b0, 16'h0789);
    seg_set(4'h5, 5'd0, 1'b1, 16'h0ABC);
    reg_io(1'b1, REG_USER_MAP, 32'h3);
    reg_io(1'b1, REG_SUPER_MAP, 32'h5);
    reg_io(1'b1, REG_CONTROL, 32'h1);
    for (i = 0; i < 4; i++) begin
      a = {5'd2, 19'($random(seed))};
      // distinct local pages so every pass really misses
      a[13:12] = 2'(i);
      xlate(a, 1'b0, pa(16'h0123, a), 1'b0, 1'b0, 1'b1, 16'h0123);
      a[11:0] = 12'($random(seed));
      xlate(a, 1'b0, pa(16'h0123, a), 1'b0, 1'b0, 1'b0, 16'h0);
    end
    reg_io(1'b1, REG_SEG_INDEX, {23'h0, 4'h3, 5'd2});
    rd(REG_SEG_ACTIVE, 32'h1);
    reg_io(1'b1, REG_USER_MAP, 32'h7);
    xlate(a, 1'b0, pa(16'h0456, a), 1'b0, 1'b0, 1'b1, 16'h0456);
    rd(REG_SEG_ACTIVE, 32'h0);
    reg_io(1'b1, REG_USER_MAP, 32'h3);
    xlate(a, 1'b0, pa(16'h0123, a), 1'b0, 1'b0, 1'b1, 16'h0123);
    reg_io(1'b1, REG_SEG_PTR, 32'h0000_0F0D);
    rd(REG_SEG_ACTIVE, 32'h0);
    xlate(a, 1'b0, pa(16'h0F0D, a), 1'b0, 1'b0, 1'b1, 16'h0F0D);
    xlate({5'd4, a[18:0]}, 1'b0, 24'h0, 1'b1, 1'b0, 1'b0, 16'h0);
    // failed fills leave the record invalid, so each retry fetches again
    a[18:12] = a[18:12] + 7'h1;
    fail <= 1'b1;
    xlate(a, 1'b0, 24'h0, 1'b0, 1'b1, 1'b1, 16'h0F0D);
    fail <= 1'b0;
    narrow <= 1'b1;
    xlate(a, 1'b0, 24'h0, 1'b0, 1'b1, 1'b1, 16'h0F0D);
    narrow <= 1'b0;
    rd(REG_STATUS, 32'h3);
    rd(REG_ERR_PAGE, {20'h0, a[23:12]});
    reg_io(1'b1, REG_STATUS, 32'h3);
    rd(REG_STATUS, 32'h0);
    xlate(a, 1'b0, pa(16'h0F0D, a), 1'b0, 1'b0, 1'b1, 16'h0F0D);
    a = {12'h000, 12'($random(seed))};
    xlate(a, 1'b1, pa(16'h0ABC, a), 1'b0, 1'b0, 1'b1, 16'h0ABC);
    reg_io(1'b1, REG_CONTROL, 32'h0);
    xlate(24'hABC123, 1'b0, 24'hABC123, 1'b0, 1'b0, 1'b0, 16'h0);
    end_sim();
  end
endmodule
